// ### sep_pkg.sv
// Purpose: shared constants and carriers for the serial eeprom select/protect
// Assumes: 100 MHz system clock, serial clock as a separate link domain
// Notes:   opcodes and status bit positions as seen on the serial bus
package sep_pkg;

  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam int unsigned TWC_MAX_MS    = 5;
  // longest time, rounded down to whole cycles
  localparam int unsigned WRITE_CYCLES  = TWC_MAX_MS * (CLK_FREQ_HZ / 1000);

  localparam int unsigned MEM_ADDR_W    = 11;
  localparam int unsigned PAGE_W        = 4;

  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_WRITE       = 8'h02;
  localparam logic [7:0] OP_WRDI        = 8'h04;
  localparam logic [7:0] OP_WREN        = 8'h06;
  localparam logic [7:0] OP_RDSR        = 8'h05;
  localparam logic [7:0] OP_WRSR        = 8'h01;

  localparam int unsigned SR_PROTECT_PIN_ENABLE_BIT = 7;
  localparam int unsigned SR_BP1        = 3;
  localparam int unsigned SR_BP0        = 2;
  localparam int unsigned SR_WEL        = 1;
  localparam int unsigned SR_WIP        = 0;
  localparam logic [7:0]  SR_RESET      = 8'h00;

  // full bytes seen in a frame: opcode, address high, address low, data
  localparam logic [2:0] BYTES_NONE     = 3'h0;
  localparam logic [2:0] BYTES_OPC      = 3'h1;
  localparam logic [2:0] BYTES_STAT     = 3'h2;
  localparam logic [2:0] BYTES_ADDR     = 3'h3;
  localparam logic [2:0] BYTES_DATA     = 3'h4;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [4:0] PAGE_END       = 5'h10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10
  } sep_state_t;

  // link-side capture; stable while chip select is high
  typedef struct packed {
    logic [7:0]       op;
    logic [15:0]      addr;
    logic [2:0]       bytes;
    logic             boundary;
    logic [15:0]      mask;
    logic [15:0][7:0] page;
    logic [7:0]       shift;
    logic [7:0]       tx;
    logic             tx_on;
  } sep_cmd_t;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic       fresh;
  } sep_frame_t;

  typedef struct packed {
    logic       so;
    logic       oe;
  } sep_so_t;

  typedef struct packed {
    sep_state_t       state;
    logic             cs_q;
    logic             armed;
    logic             selected;
    logic             standby;
    logic             wel;
    logic             protect_pin_enable_bit;
    logic [1:0]       bp;
    logic             to_status;
    logic [15:0]      addr;
    logic [15:0]      mask;
    logic [15:0][7:0] page;
    logic [4:0]       wr_idx;
    logic [31:0]      timer;
    logic [7:0]       status;
  } sep_sys_t;

endpackage

// ### sep_sync.sv
// Purpose: two-stage level synchroniser
// Assumes: input is a level, held long against the destination clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module sep_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [1:0][W-1:0] sync_ff;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= {sync_ff[0], i_d};
    end
  end

  assign o_q = sync_ff[1];

endmodule // sep_sync

// ### sep_so_drive.sv
// Purpose: serial output bit and its enable, on the falling serial clock
// Assumes: i_clr high whenever deselected or paused
// Notes:   enable drops at once on i_clr, no clock edge needed
`timescale 1ns/1ns
module sep_so_drive (
  input  wire logic i_sck,
  input  wire logic i_clr,
  input  wire logic i_tx_bit,
  input  wire logic i_tx_on,
  output logic      o_so,
  output logic      o_so_oe
);

  sep_pkg::sep_so_t so_ff;
  sep_pkg::sep_so_t nxt_so;

  always_comb begin
    nxt_so    = so_ff;
    nxt_so.so = i_tx_bit;
    nxt_so.oe = i_tx_on;
  end

  always_ff @(negedge i_sck or posedge i_clr) begin
    if (i_clr) begin
      so_ff <= '0;
    end else begin
      so_ff <= nxt_so;
    end
  end

  assign o_so    = so_ff.so;
  assign o_so_oe = so_ff.oe;

endmodule // sep_so_drive

// ### sep_top.sv
// What this block does
// - chip select low selects the device and high deselects it into standby.
// - a started programming cycle runs to its end whatever chip select does.
// - standby after a mid-program deselect waits for the cycle to finish.
// - the serial output floats whenever the device is deselected.
// - a write cycle starts only on chip select rising after a whole sequence.
// - after power-up nothing is acted on until chip select has been low once.
// - read data changes on the serial output after a falling serial clock.
// - pin low with the protect-enable bit set refuses status register writes.
// - that lockout leaves reads, array writes and latch commands untouched.
// - pin high lets every operation through, status writes included.
// - the pin falling after a write cycle started does not disturb it.
// - with the protect-enable bit clear the pin is ignored altogether.
// - each internal write cycle ends within 5 ms of its start.
// - input bits are taken on the rising serial clock, msb first.
// - the protect-enable flag is bit 7 of the status byte read back.
// - pause low floats the output and freezes the sequence in place.
//
// Purpose: select, write-timing and write-protect control of a serial eeprom
// Assumes: i_sck clocks the link; i_cs_n, i_si, i_hold_n meet set-up to it
// Notes:   memory and status live in the system domain
`timescale 1ns/1ns
module sep_top #(
  parameter int unsigned P_WRITE_CYCLES = sep_pkg::WRITE_CYCLES,
  parameter int unsigned P_ADDR_W       = sep_pkg::MEM_ADDR_W
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  input  wire logic       i_hold_n,
  input  wire logic       i_wp_n,
  output logic            o_so,
  output logic            o_so_oe,
  output logic            o_selected,
  output logic            o_standby,
  output logic            o_busy,
  output logic [7:0]      o_status
);

  localparam int unsigned DEPTH = 1 << P_ADDR_W;

  // block protection: none, upper quarter, upper half, whole array
  function automatic logic prot_hit(input logic [1:0]  bp,
                                    input logic [15:0] addr);
    logic [1:0] top;
    top = addr[P_ADDR_W-1 -: 2];
    case (bp)
      2'h0:    prot_hit = 1'b0;
      2'h1:    prot_hit = (top == 2'h3);
      2'h2:    prot_hit = top[1];
      default: prot_hit = 1'b1;
    endcase
  endfunction

  logic [7:0]        mem [DEPTH];

  logic              rst_n;
  logic [1:0]        pin_s;
  logic              cs_s;
  logic              wp_s;
  logic [8:0]        link_s;
  logic              armed_l;
  logic [7:0]        status_l;

  sep_pkg::sep_sys_t   sys_ff;
  sep_pkg::sep_sys_t   nxt_sys;
  sep_pkg::sep_cmd_t   cmd_ff;
  sep_pkg::sep_cmd_t   nxt_cmd;
  sep_pkg::sep_frame_t frame_ff;
  sep_pkg::sep_frame_t nxt_frame;

  logic              cs_rise;
  logic              wp_lock;
  logic              mem_we;
  logic [15:0]       mem_wa;
  logic [7:0]        rx_byte;
  logic [15:0]       rd_addr;

  // reset release through two flops
  sep_sync #(.W(1)) u_rst_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    (1'b1),
    .o_q    (rst_n)
  );

  // pins synced inverted: the flops' reset value then reads as idle pins,
  // so no false select arms the device before cs was ever low
  sep_sync #(.W(2)) u_pin_sync (
    .i_clk  (i_clk),
    .i_rstn (rst_n),
    .i_d    (~{i_cs_n, i_wp_n}),
    .o_q    (pin_s)
  );

  assign cs_s = ~pin_s[1];
  assign wp_s = ~pin_s[0];

  // status and arm level carried into the serial clock domain
  sep_sync #(.W(9)) u_link_sync (
    .i_clk  (i_sck),
    .i_rstn (rst_n),
    .i_d    ({sys_ff.armed, sys_ff.status}),
    .o_q    (link_s)
  );

  assign armed_l  = link_s[8];
  assign status_l = link_s[7:0];

  // ---------------- link domain, rising serial clock ----------------

  always_comb begin
    nxt_cmd   = cmd_ff;
    nxt_frame = frame_ff;
    rx_byte   = {cmd_ff.shift[6:0], i_si};
    rd_addr   = cmd_ff.addr + 16'h0001;
    // sck may toggle for other slaves while deselected: ignore it
    if (!i_cs_n && armed_l && i_hold_n) begin
      if (frame_ff.fresh) begin
        nxt_cmd.bytes    = sep_pkg::BYTES_NONE;
        nxt_cmd.mask     = '0;
        nxt_cmd.tx_on    = 1'b0;
        nxt_frame.fresh  = 1'b0;
      end
      nxt_cmd.shift     = rx_byte;
      nxt_frame.bit_cnt = frame_ff.bit_cnt + 3'h1;
      nxt_cmd.boundary  = 1'b0;
      if (cmd_ff.tx_on) begin
        nxt_cmd.tx = {cmd_ff.tx[6:0], 1'b0};
      end
      if (frame_ff.bit_cnt == sep_pkg::BIT_LAST) begin
        nxt_cmd.boundary = 1'b1;
        if (nxt_cmd.bytes != sep_pkg::BYTES_DATA) begin
          nxt_cmd.bytes = nxt_cmd.bytes + 3'h1;
        end
        if (nxt_cmd.bytes == sep_pkg::BYTES_OPC) begin
          nxt_cmd.op = rx_byte;
          if (rx_byte == sep_pkg::OP_RDSR) begin
            nxt_cmd.tx    = status_l;
            nxt_cmd.tx_on = 1'b1;
          end
        end else if (cmd_ff.op == sep_pkg::OP_RDSR) begin
          nxt_cmd.tx = status_l; // repeats for polling
        end else if (cmd_ff.op == sep_pkg::OP_WRSR) begin
          if (nxt_cmd.bytes == sep_pkg::BYTES_STAT) begin
            nxt_cmd.page[0] = rx_byte;
            nxt_cmd.mask[0] = 1'b1;
          end
        end else if (nxt_cmd.bytes == sep_pkg::BYTES_STAT) begin
          nxt_cmd.addr[15:8] = rx_byte;
        end else if (nxt_cmd.bytes == sep_pkg::BYTES_ADDR) begin
          nxt_cmd.addr[7:0] = rx_byte;
          if (cmd_ff.op == sep_pkg::OP_READ) begin
            // array is not readable during a write cycle
            rd_addr       = {cmd_ff.addr[15:8], rx_byte};
            nxt_cmd.tx    = mem[rd_addr[P_ADDR_W-1:0]];
            nxt_cmd.tx_on = !status_l[sep_pkg::SR_WIP];
          end
        end else if (cmd_ff.op == sep_pkg::OP_READ) begin
          nxt_cmd.addr = rd_addr;
          nxt_cmd.tx   = mem[rd_addr[P_ADDR_W-1:0]];
        end else if (cmd_ff.op == sep_pkg::OP_WRITE) begin
          // page wraps inside itself
          nxt_cmd.page[cmd_ff.addr[sep_pkg::PAGE_W-1:0]] = rx_byte;
          nxt_cmd.mask[cmd_ff.addr[sep_pkg::PAGE_W-1:0]] = 1'b1;
          nxt_cmd.addr[sep_pkg::PAGE_W-1:0] =
            cmd_ff.addr[sep_pkg::PAGE_W-1:0] + 4'h1;
        end
      end
    end
  end

  // bit position restarts with every deselect
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      frame_ff.bit_cnt <= 3'h0;
      frame_ff.fresh   <= 1'b1;
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  // captured frame survives deselect so the system side can act on it
  always_ff @(posedge i_sck or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  // clear is a pin level; both sources are quiet while data is valid
  sep_so_drive u_so (
    .i_sck    (i_sck),
    .i_clr    (i_cs_n | ~i_hold_n),
    .i_tx_bit (cmd_ff.tx[7]),
    .i_tx_on  (cmd_ff.tx_on),
    .o_so     (o_so),
    .o_so_oe  (o_so_oe)
  );

  // ---------------- system domain ----------------

  assign cs_rise = cs_s && !sys_ff.cs_q;
  // pin acts only while the protect-enable bit is set
  assign wp_lock = sys_ff.protect_pin_enable_bit && !wp_s;

  always_comb begin
    nxt_sys          = sys_ff;
    nxt_sys.cs_q     = cs_s;
    nxt_sys.selected = !cs_s;
    if (!cs_s) begin
      nxt_sys.armed = 1'b1;
    end
    // cmd_ff is read only after cs rose and was synced: sck is idle then
    case (sys_ff.state)
      sep_pkg::ST_IDLE: begin
        if (cs_rise && sys_ff.armed && cmd_ff.boundary) begin
          case (cmd_ff.op)
            sep_pkg::OP_WREN: begin
              if (cmd_ff.bytes == sep_pkg::BYTES_OPC) begin
                nxt_sys.wel = 1'b1;
              end
            end
            sep_pkg::OP_WRDI: begin
              if (cmd_ff.bytes == sep_pkg::BYTES_OPC) begin
                nxt_sys.wel = 1'b0;
              end
            end
            sep_pkg::OP_WRSR: begin
              if (cmd_ff.bytes == sep_pkg::BYTES_STAT && sys_ff.wel &&
                  !wp_lock) begin
                nxt_sys.state     = sep_pkg::ST_PROG;
                nxt_sys.to_status = 1'b1;
                nxt_sys.page      = cmd_ff.page;
                nxt_sys.timer     = 32'(P_WRITE_CYCLES - 1);
              end
            end
            sep_pkg::OP_WRITE: begin
              if (cmd_ff.bytes == sep_pkg::BYTES_DATA && sys_ff.wel &&
                  cmd_ff.mask != '0 &&
                  !prot_hit(sys_ff.bp, cmd_ff.addr)) begin
                nxt_sys.state     = sep_pkg::ST_PROG;
                nxt_sys.to_status = 1'b0;
                nxt_sys.page      = cmd_ff.page;
                nxt_sys.mask      = cmd_ff.mask;
                nxt_sys.addr      = cmd_ff.addr;
                nxt_sys.wr_idx    = 5'h00;
                nxt_sys.timer     = 32'(P_WRITE_CYCLES - 1);
              end
            end
            default: begin
              nxt_sys.wel = sys_ff.wel;
            end
          endcase
        end
      end
      sep_pkg::ST_PROG: begin
        // neither cs nor the protect pin is looked at here
        if (sys_ff.wr_idx != sep_pkg::PAGE_END) begin
          nxt_sys.wr_idx = sys_ff.wr_idx + 5'h01;
        end
        nxt_sys.timer = sys_ff.timer - 32'h1;
        if (sys_ff.timer == '0) begin
          nxt_sys.state = sep_pkg::ST_IDLE;
          nxt_sys.wel   = 1'b0;
          if (sys_ff.to_status) begin
            nxt_sys.protect_pin_enable_bit =
              sys_ff.page[0][sep_pkg::SR_PROTECT_PIN_ENABLE_BIT];
            nxt_sys.bp   = {sys_ff.page[0][sep_pkg::SR_BP1],
                            sys_ff.page[0][sep_pkg::SR_BP0]};
          end
        end
      end
      default: begin
        nxt_sys.state = sep_pkg::ST_IDLE;
      end
    endcase
    nxt_sys.standby = cs_s && (nxt_sys.state == sep_pkg::ST_IDLE);
    nxt_sys.status  = sep_pkg::SR_RESET;
    nxt_sys.status[sep_pkg::SR_PROTECT_PIN_ENABLE_BIT] =
      nxt_sys.protect_pin_enable_bit;
    nxt_sys.status[sep_pkg::SR_BP1]  = nxt_sys.bp[1];
    nxt_sys.status[sep_pkg::SR_BP0]  = nxt_sys.bp[0];
    nxt_sys.status[sep_pkg::SR_WEL]  = nxt_sys.wel;
    nxt_sys.status[sep_pkg::SR_WIP]  =
      (nxt_sys.state == sep_pkg::ST_PROG);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_ff          <= '0;
      sys_ff.state    <= sep_pkg::ST_IDLE;
      sys_ff.cs_q     <= 1'b1;
      sys_ff.standby  <= 1'b1;
      sys_ff.wr_idx   <= sep_pkg::PAGE_END;
      sys_ff.status   <= sep_pkg::SR_RESET;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  // one page byte per cycle at the start of the program cycle
  assign mem_wa = {sys_ff.addr[15:sep_pkg::PAGE_W],
                   sys_ff.wr_idx[sep_pkg::PAGE_W-1:0]};
  assign mem_we = (sys_ff.state == sep_pkg::ST_PROG) && !sys_ff.to_status &&
                  (sys_ff.wr_idx != sep_pkg::PAGE_END) &&
                  sys_ff.mask[sys_ff.wr_idx[sep_pkg::PAGE_W-1:0]];

  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_wa[P_ADDR_W-1:0]] <= sys_ff.page[mem_wa[sep_pkg::PAGE_W-1:0]];
    end
  end

  assign o_selected = sys_ff.selected;
  assign o_standby  = sys_ff.standby;
  assign o_busy     = sys_ff.status[sep_pkg::SR_WIP];
  assign o_status   = sys_ff.status;

endmodule // sep_top

// ### sep_chk.sv
// Purpose: port-level assertions for sep_top
// Assumes: all checks sampled on the system clock
// Notes:   cs stretches leave room for the two-flop sync latency
`timescale 1ns/1ns
module sep_chk #(
  parameter int unsigned P_WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_sck,
  input wire logic       i_cs_n,
  input wire logic       i_si,
  input wire logic       i_hold_n,
  input wire logic       i_wp_n,
  input wire logic       o_so,
  input wire logic       o_so_oe,
  input wire logic       o_selected,
  input wire logic       o_standby,
  input wire logic       o_busy,
  input wire logic [7:0] o_status
);
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;

  always_comb nxt_busy_cnt = o_busy ? busy_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) busy_cnt_ff <= 32'h0;
    else busy_cnt_ff <= nxt_busy_cnt;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_desel; i_cs_n [*5]; endsequence
  sequence s_sel; !i_cs_n [*5]; endsequence

  a_desel_idle:
    assert property (s_desel |-> !o_selected) else $error("selected late");
  a_sel_wakes:
    assert property (s_sel |-> o_selected && !o_standby)
    else $error("not selected");
  a_oe_desel:
    assert property (i_cs_n |-> !o_so_oe) else $error("so driven idle");
  a_oe_pause:
    assert property (!i_hold_n |-> !o_so_oe) else $error("so driven paused");
  a_busy_standby:
    assert property (o_busy |-> !o_standby) else $error("standby in write");
  a_busy_length:
    assert property ($fell(o_busy) |-> busy_cnt_ff >= P_WRITE_CYCLES - 1 &&
      busy_cnt_ff <= P_WRITE_CYCLES) else $error("write length wrong");
  a_standby_end:
    assert property ($fell(o_busy) && i_cs_n && $past(i_cs_n, 4) |->
      o_standby) else $error("no standby after write");
  a_start_on_rise:
    assert property ($rose(o_busy) |-> $past(i_cs_n, 3) && o_status[1])
    else $error("write start bad");
  a_end_clears_wel:
    assert property ($fell(o_busy) |-> !o_status[1] && !o_status[0])
    else $error("latch kept");
  a_busy_status_hold:
    assert property (o_busy && $past(o_busy) |-> $stable(o_status))
    else $error("status moved in write");
endmodule // sep_chk

bind sep_top sep_chk #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_selected(o_selected), .o_standby(o_standby),
  .o_busy(o_busy), .o_status(o_status));

// ### sep_master.sv
// Purpose: serial bus master model facing the eeprom pins
// Assumes: mode 0, 15 ns serial clock only inside frames
// Notes:   si shows the inverse of its last bit between frames
`timescale 1ns/1ns
module sep_master (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end

  // nbits below a byte multiple cuts the frame short on purpose
  task automatic frame(input logic [31:0] tx, input int nbits,
                       input int pause_at, output logic [31:0] rx);
    rx = 32'h0;
    o_cs_n = 1'b0;
    #20;
    for (int i = 0; i < nbits; i++) begin
      if (i == pause_at) begin
        o_hold_n = 1'b0;
        repeat (2) begin
          #7 o_sck = 1'b1;
          #8 o_sck = 1'b0;
          o_si = ~o_si;
        end
        o_hold_n = 1'b1;
        #8;
      end
      o_si = tx[31 - i];
      #8 o_sck = 1'b1;
      rx = {rx[30:0], i_so & i_so_oe};
      #7 o_sck = 1'b0;
    end
    #20 o_cs_n = 1'b1;
    o_si = ~o_si;
    #500;
  endtask
endmodule // sep_master

// ### test_serial_eeprom_select_and_protect.sv
// Purpose: self-checking bench for sep_top
// Assumes: write cycle shortened to 200 system clocks
// Notes:   frames come from sep_master, pin wp from here
`timescale 1ns/1ns
module test_serial_eeprom_select_and_protect;
  localparam int unsigned P_WC = 200;
  logic        i_clk;
  logic        i_rstn;
  logic        i_wp_n;
  logic        sck, cs_n, si, hold_n, so, so_oe, selected, standby, busy;
  logic [7:0]  status;
  logic [31:0] rx;
  logic [15:0] lf;
  int          n_fail;
  int          samples_checked;

  sep_master u_mst (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
    .o_hold_n(hold_n), .i_so(so), .i_so_oe(so_oe));
  sep_top #(.P_WRITE_CYCLES(P_WC)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n),
    .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .o_selected(selected),
    .o_standby(standby), .o_busy(busy), .o_status(status));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] sr(input logic prot_en,
                                    input logic [1:0] bp,
                                    input logic wel, input logic wip);
    return {prot_en, 3'h0, bp, wel, wip};
  endfunction

  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [31:0] tx, input int nb);
    logic [31:0] dummy;
    u_mst.frame(tx, nb, 99, dummy);
  endtask

  task automatic rdsr(input logic [7:0] exp, input int pause_at);
    u_mst.frame({sep_pkg::OP_RDSR, 24'h0}, 16, pause_at, rx);
    chk(rx[7:0], exp);
  endtask

  // bounded wait for a write cycle, then for its end
  task automatic run_cycle(input logic exp);
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    chk(busy, exp);
    k = 0;
    while (busy === 1'b1 && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    @(negedge i_clk);
    chk({busy, standby}, 2'b01);
  endtask

  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  initial begin
    logic [10:0] a;
    logic [7:0]  d;
    n_fail = 0;
    samples_checked = 0;
    lf = 16'h0010;
    i_rstn = 1'b0;
    i_wp_n = 1'b1;
    repeat (6) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (4) begin
      @(negedge i_clk);
      chk({selected, standby, busy}, 3'b010);
    end
    cmd({sep_pkg::OP_WREN, 24'h0}, 8);
    cmd({sep_pkg::OP_WREN, 24'h0}, 4);
    rdsr(sr(1'b0, 2'h0, 1'b0, 1'b0), 99);
    cmd({sep_pkg::OP_WREN, 24'h0}, 8);
    rdsr(sr(1'b0, 2'h0, 1'b1, 1'b0), 3);
    lf = lfsr(lf);
    cmd({sep_pkg::OP_WRITE, 5'h0, lf[10:0], 8'h5a}, 28);
    run_cycle(1'b0);
    cmd({sep_pkg::OP_WRSR, 8'h80, 16'h0}, 16);
    run_cycle(1'b1);
    rdsr(sr(1'b1, 2'h0, 1'b0, 1'b0), 99);
    @(negedge i_clk) i_wp_n = 1'b0;
    cmd({sep_pkg::OP_WREN, 24'h0}, 8);
    cmd({sep_pkg::OP_WRSR, 8'h0c, 16'h0}, 16);
    run_cycle(1'b0);
    rdsr(sr(1'b1, 2'h0, 1'b1, 1'b0), 99);
    cmd({sep_pkg::OP_WRDI, 24'h0}, 8);
    rdsr(sr(1'b1, 2'h0, 1'b0, 1'b0), 99);
    for (int j = 0; j < 3; j++) begin
      lf = lfsr(lf);
      a = lf[10:0];
      lf = lfsr(lf);
      d = lf[7:0];
      cmd({sep_pkg::OP_WREN, 24'h0}, 8);
      cmd({sep_pkg::OP_WRITE, 5'h0, a, d}, 32);
      rdsr(sr(1'b1, 2'h0, 1'b1, 1'b1), 99);
      run_cycle(1'b1);
      u_mst.frame({sep_pkg::OP_READ, 5'h0, a, 8'h0}, 32, 99, rx);
      chk(rx[7:0], d);
    end
    @(negedge i_clk) i_wp_n = 1'b1;
    cmd({sep_pkg::OP_WREN, 24'h0}, 8);
    cmd({sep_pkg::OP_WRSR, 8'h00, 16'h0}, 16);
    @(negedge i_clk) i_wp_n = 1'b0;
    run_cycle(1'b1);
    rdsr(sr(1'b0, 2'h0, 1'b0, 1'b0), 99);
    cmd({sep_pkg::OP_WREN, 24'h0}, 8);
    cmd({sep_pkg::OP_WRSR, 8'h04, 16'h0}, 16);
    run_cycle(1'b1);
    rdsr(sr(1'b0, 2'h1, 1'b0, 1'b0), 99);
    finish_test();
  end
endmodule // test_serial_eeprom_select_and_protect
